// ==== hdl/rad_defs.vh ====
// rad_defs.vh: offsets, field positions, reset values and encodings
// assumes inclusion by bare name from the decoder top
`ifndef RAD_DEFS_VH
`define RAD_DEFS_VH

// register byte offsets (32-bit aligned words)
`define RAD_OFS_RNR         4'h0
`define RAD_OFS_RASR        4'h4
`define RAD_OFS_STAT        4'h8
`define RAD_OFS_FETCH       4'hC

// field positions of the attribute register
`define RAD_EXEC_NEVER_BIT  28
`define RAD_ACC_PERM_HI     26
`define RAD_ACC_PERM_LO     24
`define RAD_TYPE_EXT_HI     21
`define RAD_TYPE_EXT_LO     19
`define RAD_S_BIT           18
`define RAD_C_BIT           17
`define RAD_B_BIT           16
`define RAD_SUB_DIS_HI      15
`define RAD_SUB_DIS_LO      8
`define RAD_SIZE_HI         5
`define RAD_SIZE_LO         1
`define RAD_EN_BIT          0

// writable bits of the attribute register
`define RAD_RASR_MASK       32'h173FFF3F
`define RAD_RASR_RST        32'h00000000
`define RAD_RNR_RST         8'h00

// size code at or below which subregions do not exist (128 bytes)
`define RAD_SIZE_NOSUB      5'h06

// memory types
`define RAD_MT_STRONG       3'h0
`define RAD_MT_DEVICE       3'h1
`define RAD_MT_NORMAL       3'h2
`define RAD_MT_RESERVED     3'h3
`define RAD_MT_IMPDEF       3'h4

// cache policy codes
`define RAD_CP_NC           2'h0
`define RAD_CP_WBWA         2'h1
`define RAD_CP_WTNA         2'h2
`define RAD_CP_WBNA         2'h3

// axi response codes
`define RAD_RESP_OKAY       2'h0
`define RAD_RESP_SLVERR     2'h2

`endif

// ==== hdl/rad_region_attribute_decoder.v ====
// rad_region_attribute_decoder.v: region attribute register and decoder
// assumes an axi4-lite master on aclk and a core that asks about fetches
// assumes lookup inputs come from logic on aclk, so they are not synchronised
//
// Contract
// - execute-never bit 28 set blocks instruction fetches; clear permits them.
// - each subregion-disable bit 15:8 disables its subregion when set.
// - regions of 128 bytes or less have no subregions at all.
// - attribute register takes word and halfword writes; upper half attributes, lower size.
// - register serves region chosen by region number; fixed bit positions.
// - ext 000, C 0: strongly-ordered if B 0, device if B 1; shareable.
// - ext 000, C 1, B 0: normal write-through, no allocate; shareable per S.
// - ext 000, C 1, B 1: normal write-back, no allocate; shareable per S.
// - ext 001, C 0, B 0: normal noncacheable; shareable per S.
// - ext 001: C0B1 reserved, C1B0 implementation defined, C1B1 write-back allocate.
// - top ext bit set: cached normal; ext low bits outer, C,B inner.
// - policy code 00 nc, 01 wb-alloc, 10 wt-no-alloc, 11 wb-no-alloc.
// - don't-care bits are ignored when decoding memory attributes.
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "rad_defs.vh"

module rad_region_attribute_decoder #(
    parameter NUM_REGIONS = 8,
    parameter RNR_W       = 3
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [RNR_W-1:0] lookup_region,
    input  wire [2:0]  lookup_subregion,
    input  wire        lookup_fetch,
    output reg         region_enable,
    output reg         subregion_active,
    output reg         fetch_allowed,
    output reg  [2:0]  mem_type,
    output reg         shareable,
    output reg  [1:0]  outer_policy,
    output reg  [1:0]  inner_policy,
    output reg  [2:0]  access_permission
);

    ////////////////////////////////////////////////////////////////////////
    // storage

    // per-region attribute words and the region selector
    reg  [31:0]      attr_r [0:NUM_REGIONS-1];
    reg  [RNR_W-1:0] region_number_r;
    // halves of a write that arrived one channel at a time
    reg  [3:0]       awaddr_r;
    reg              aw_held_r;
    reg  [31:0]      wdata_r;
    reg  [3:0]       wstrb_r;
    reg              w_held_r;
    reg  [31:0]      decode_stat_r;

    // held copy of a channel wins over the live bus
    wire [3:0]       aw_addr  = aw_held_r ? awaddr_r : s_axi_awaddr;
    wire [31:0]      w_data   = w_held_r ? wdata_r : s_axi_wdata;
    wire [3:0]       w_strb   = w_held_r ? wstrb_r : s_axi_wstrb;
    wire             aw_have  = aw_held_r | s_axi_awvalid;
    wire             w_have   = w_held_r | s_axi_wvalid;
    // a write completes once both halves are in and no answer waits
    wire             wr_fire  = aw_have & w_have & ~s_axi_bvalid;
    wire             rd_fire  = s_axi_arvalid & s_axi_arready;

    // ready is combinational so a channel is taken the cycle it appears
    // address and data accepted separately, held until both are in
    assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    ////////////////////////////////////////////////////////////////////////
    // byte-lane merge: word and halfword writes both land

    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  strb;
        integer      k;
        begin
            merge = old_v;
            for (k = 0; k < 4; k = k + 1) begin
                if (strb[k]) begin
                    merge[k*8 +: 8] = new_v[k*8 +: 8];
                end
            end
            // bits outside the writable mask read back as zero, so
            // software cannot park stray state in unused positions
            merge = merge & `RAD_RASR_MASK;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write channel holding registers and response

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r    <= 1'b0;
            awaddr_r     <= 4'h0;
            w_held_r     <= 1'b0;
            wdata_r      <= 32'h00000000;
            wstrb_r      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RAD_RESP_OKAY;
        end else begin
            // answer leaves on the bready edge; new writes wait for that,
            // which keeps one write in flight and loses no address
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // unmapped and read-only offsets answer slverr, change nothing
                if (aw_addr == `RAD_OFS_RNR || aw_addr == `RAD_OFS_RASR) begin
                    s_axi_bresp <= `RAD_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `RAD_RESP_SLVERR;
                end
            end else begin
                // park whichever half arrives first
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held_r <= 1'b1;
                    awaddr_r  <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held_r <= 1'b1;
                    wdata_r  <= s_axi_wdata;
                    wstrb_r  <= s_axi_wstrb;
                end
            end
        end
    end

    // region number selects the target region
    // only the low byte lane carries the region number
    always @(posedge aclk) begin
        if (!aresetn) begin
            region_number_r <= {RNR_W{1'b0}};
        end else if (wr_fire && aw_addr == `RAD_OFS_RNR && w_strb[0]) begin
            region_number_r <= w_data[RNR_W-1:0];
        end
    end

    // one attribute word per region
    // selector widened to the loop counter so the compare is width-matched
    genvar g;
    generate
        for (g = 0; g < NUM_REGIONS; g = g + 1) begin : g_reg
            always @(posedge aclk) begin
                if (!aresetn) begin
                    attr_r[g] <= `RAD_RASR_RST;
                end else if (wr_fire && aw_addr == `RAD_OFS_RASR &&
                             {{(32-RNR_W){1'b0}}, region_number_r} == g) begin
                    attr_r[g] <= merge(attr_r[g], w_data, w_strb);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // attribute decode

    function [9:0] decode;  // {type[2:0], share, outer[1:0], inner[1:0], pad[1:0]}
        input [2:0] ext;
        input       c;
        input       b;
        input       s;
        reg   [2:0] mt;
        reg         sh;
        reg   [1:0] op;
        reg   [1:0] ip;
        begin
            // every encoding starts reserved, non-shareable and non-cacheable,
            // so a combination not named below decodes safely
            mt = `RAD_MT_RESERVED;
            sh = 1'b0;
            op = `RAD_CP_NC;
            ip = `RAD_CP_NC;
            if (ext[2]) begin
                // cached normal, outer from ext, inner from C,B
                mt = `RAD_MT_NORMAL;
                sh = s;
                op = ext[1:0];
                ip = {c, b};
            end else begin
                case (ext[1:0])
                    2'h0: begin
                        if (!c) begin
                            mt = b ? `RAD_MT_DEVICE : `RAD_MT_STRONG;
                            sh = 1'b1;
                        end else begin
                            mt = `RAD_MT_NORMAL;
                            sh = s;
                            // inner and outer policy match for these codes
                            op = b ? `RAD_CP_WBNA : `RAD_CP_WTNA;
                            ip = op;
                        end
                    end
                    2'h1: begin
                        case ({c, b})
                            2'h0: begin
                                mt = `RAD_MT_NORMAL;
                                sh = s;
                            end
                            2'h1: mt = `RAD_MT_RESERVED;
                            2'h2: mt = `RAD_MT_IMPDEF;
                            default: begin
                                mt = `RAD_MT_NORMAL;
                                sh = s;
                                op = `RAD_CP_WBWA;
                                ip = `RAD_CP_WBWA;
                            end
                        endcase
                    end
                    2'h2: begin
                        if (!c && !b) begin
                            mt = `RAD_MT_DEVICE;
                        end
                    end
                    // ext 011 has no assigned meaning: reserved
                    default: mt = `RAD_MT_RESERVED;
                endcase
            end
            decode = {mt, sh, op, ip, 2'h0};
        end
    endfunction

    // lookup path reads the queried region, software view the selected one
    wire [31:0] look_w = attr_r[lookup_region];
    wire [31:0] sel_w  = attr_r[region_number_r];
    wire [9:0]  look_d = decode(look_w[`RAD_TYPE_EXT_HI:`RAD_TYPE_EXT_LO], look_w[`RAD_C_BIT],
                                look_w[`RAD_B_BIT], look_w[`RAD_S_BIT]);
    wire [9:0]  sel_d  = decode(sel_w[`RAD_TYPE_EXT_HI:`RAD_TYPE_EXT_LO], sel_w[`RAD_C_BIT],
                                sel_w[`RAD_B_BIT], sel_w[`RAD_S_BIT]);
    // small region: size code at or below the no-subregion limit
    wire        look_nosub = (look_w[`RAD_SIZE_HI:`RAD_SIZE_LO] <= `RAD_SIZE_NOSUB);
    // disable bit of the queried subregion
    wire        look_off   = look_w[`RAD_SUB_DIS_LO + lookup_subregion];

    // registered lookup outputs, one cycle after the query
    // outputs are recomputed every cycle from the lookup inputs and the queried attribute word
    always @(posedge aclk) begin
        if (!aresetn) begin
            region_enable     <= 1'b0;
            subregion_active  <= 1'b0;
            fetch_allowed     <= 1'b0;
            mem_type          <= `RAD_MT_STRONG;
            shareable         <= 1'b0;
            outer_policy      <= `RAD_CP_NC;
            inner_policy      <= `RAD_CP_NC;
            access_permission <= 3'h0;
        end else begin
            // a disabled region never reports a live subregion or a fetch
            region_enable <= look_w[`RAD_EN_BIT];
            // small regions ignore the disable bits
            subregion_active <= look_w[`RAD_EN_BIT] & (look_nosub | ~look_off);
            // execute-never blocks fetches
            // fetch needs the query, an enabled region and a live subregion
            fetch_allowed     <= lookup_fetch & look_w[`RAD_EN_BIT] & ~look_w[`RAD_EXEC_NEVER_BIT]
                                 & (look_nosub | ~look_off);
            mem_type          <= look_d[9:7];
            shareable         <= look_d[6];
            outer_policy      <= look_d[5:4];
            inner_policy      <= look_d[3:2];
            // access permission passes through undecoded
            access_permission <= look_w[`RAD_ACC_PERM_HI:`RAD_ACC_PERM_LO];
        end
    end

    // decoded view of the selected region for software
    // status lags the register by one cycle, so a read right after
    // an attribute write may still see the old decode
    // bit 0 fetch ok, 2:1 inner, 4:3 outer, 5 share, 8:6 type
    always @(posedge aclk) begin
        if (!aresetn) begin
            decode_stat_r <= 32'h00000000;
        end else begin
            decode_stat_r <= {23'h000000, sel_d[9:2], ~sel_w[`RAD_EXEC_NEVER_BIT]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RAD_RESP_OKAY;
        end else begin
            // one read in flight: answer leaves on the rready edge
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RAD_RESP_OKAY;
                case (s_axi_araddr)
                    `RAD_OFS_RNR:   s_axi_rdata <= {{(32-RNR_W){1'b0}}, region_number_r};
                    `RAD_OFS_RASR:  s_axi_rdata <= sel_w;
                    `RAD_OFS_STAT:  s_axi_rdata <= decode_stat_r;
                    // unmapped offsets read as zero with slverr
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `RAD_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

endmodule

// ==== verif/rad_region_attribute_decoder_props.sv ====
// rad_region_attribute_decoder_props.sv: port checks for the decoder
// assumes binding onto the decoder top, single aclk domain
`timescale 1ns/1ps

module rad_region_attribute_decoder_props (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic       lookup_fetch,
    input wire logic       region_enable,
    input wire logic       subregion_active,
    input wire logic       fetch_allowed,
    input wire logic [2:0] mem_type,
    input wire logic       shareable,
    input wire logic [1:0] outer_policy,
    input wire logic [1:0] inner_policy
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////
    // bus handshakes
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped early");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped early");
    property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_bans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid; endproperty
    a_bans: assert property (p_bans) else $error("write answer late");

    ////////////////////////////////////////////////////////////////////////
    // lookup results
    property p_fetch; fetch_allowed |-> region_enable && subregion_active && $past(lookup_fetch); endproperty
    a_fetch: assert property (p_fetch) else $error("fetch allowed without cause");
    property p_sub; subregion_active |-> region_enable; endproperty
    a_sub: assert property (p_sub) else $error("subregion live in disabled region");
    property p_strong; region_enable && mem_type == 3'h0 |-> shareable; endproperty
    a_strong: assert property (p_strong) else $error("strongly ordered not shareable");
    property p_rsv; mem_type == 3'h3 |-> !shareable && outer_policy == 2'h0 && inner_policy == 2'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved type with attributes");

    // main scenarios reached
    c_fetch: cover property (fetch_allowed);
    c_rsv: cover property (region_enable && mem_type == 3'h3);
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind rad_region_attribute_decoder rad_region_attribute_decoder_props u_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .lookup_fetch(lookup_fetch),
    .region_enable(region_enable), .subregion_active(subregion_active), .fetch_allowed(fetch_allowed),
    .mem_type(mem_type), .shareable(shareable), .outer_policy(outer_policy), .inner_policy(inner_policy)
);

// ==== verif/rad_region_attribute_decoder_test.sv ====
// rad_region_attribute_decoder_test.sv: self-checking bench for the decoder
// assumes the decoder and its checker are compiled first
`timescale 1ns/1ps
`include "rad_defs.vh"

module rad_region_attribute_decoder_test;
    reg         aclk = 1'h0;
    reg         aresetn = 1'h0;
    reg  [3:0]  awaddr = 4'h0;
    reg  [3:0]  araddr = 4'h0;
    reg  [3:0]  wstrb = 4'h0;
    reg  [31:0] wdata = 32'h0;
    reg         awvalid = 1'h0;
    reg         wvalid = 1'h0;
    reg         bready = 1'h0;
    reg         arvalid = 1'h0;
    reg         rready = 1'h0;
    reg  [2:0]  lk_reg = 3'h0;
    reg  [2:0]  lk_sub = 3'h0;
    reg         lk_fetch = 1'h0;
    wire        awready, wready, bvalid, arready, rvalid, en, sa, fa, sh;
    wire [1:0]  bresp, rresp, op, ip;
    wire [2:0]  mt, ap;
    wire [31:0] rdata;
    integer     err_total = 0;
    integer     n_tests = 0;
    reg  [1:0]  resp;
    reg  [31:0] data;

    rad_region_attribute_decoder u_rad_region_attribute_decoder (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .lookup_region(lk_reg), .lookup_subregion(lk_sub), .lookup_fetch(lk_fetch),
        .region_enable(en), .subregion_active(sa), .fetch_allowed(fa), .mem_type(mt),
        .shareable(sh), .outer_policy(op), .inner_policy(ip), .access_permission(ap)
    );

    // 50 MHz clock
    always #10 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////////
    // compare and report
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask

    task final_report;
        begin
            $display("mismatches %0d of %0d checks", err_total, n_tests);
            if (err_total == 0 && n_tests > 0) begin
                $display("Simulation passed");
            end else begin
                $display("Simulation failed");
            end
            $finish;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // bus master: each channel released at its own handshake edge
    task wr(input [3:0] a, input [31:0] d, input [3:0] s);
        reg ta, tw, tb;
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            wstrb <= s;
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            bready <= 1'h1;
            tb = 1'h0;
            while (!tb) begin
                @(negedge aclk);
                ta = awvalid && awready;
                tw = wvalid && wready;
                tb = bvalid;
                resp = bresp;
                @(posedge aclk);
                if (ta) awvalid <= 1'h0;
                if (tw) wvalid <= 1'h0;
            end
            bready <= 1'h0;
        end
    endtask

    task rd(input [3:0] a);
        reg ta, tb;
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'h1;
            rready <= 1'h1;
            tb = 1'h0;
            while (!tb) begin
                @(negedge aclk);
                ta = arvalid && arready;
                tb = rvalid;
                data = rdata;
                resp = rresp;
                @(posedge aclk);
                if (ta) arvalid <= 1'h0;
            end
            rready <= 1'h0;
        end
    endtask

    // lookup settles one edge after its inputs
    task look(input [2:0] r, input [2:0] s, input f);
        begin
            @(posedge aclk);
            lk_reg <= r;
            lk_sub <= s;
            lk_fetch <= f;
            @(posedge aclk);
            @(negedge aclk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task t_bus;
        begin
            rd(4'h4);
            chk(data, 32'h0);
            rd(4'hC);
            chk({30'h0, resp}, {30'h0, `RAD_RESP_SLVERR});
            wr(4'h8, 32'hFFFFFFFF, 4'hF);
            chk({30'h0, resp}, {30'h0, `RAD_RESP_SLVERR});
            wr(4'h0, 32'h2, 4'hF);
            wr(4'h4, 32'hFFFFFFFF, 4'hF);
            rd(4'h4);
            chk(data, 32'h173FFF3F);
            wr(4'h0, 32'h1, 4'hF);
            rd(4'h4);
            chk(data, 32'h0);
            wr(4'h0, 32'h2, 4'hF);
            wr(4'h4, 32'h0, 4'h3);
            rd(4'h4);
            chk(data, 32'h173F0000);
            wr(4'h4, 32'h0, 4'hC);
            rd(4'h4);
            chk(data, 32'h0);
        end
    endtask

    // a = {ext, c, b, s}; e = {type, share, outer, inner}; p checks policies
    task da(input [5:0] a, input [7:0] e, input p);
        begin
            wr(4'h4, {10'h000, a[5:3], a[0], a[2], a[1], 16'h000F}, 4'hF);
            look(3'h2, 3'h0, 1'h0);
            chk({24'h0, mt, sh, p ? {op, ip} : 4'h0}, {24'h0, e});
            rd(4'h8);
            chk(data, {23'h0, e, 1'h1});
        end
    endtask

    task t_decode;
        begin
            da(6'h01, 8'h10, 1'h0);
            da(6'h02, 8'h30, 1'h0);
            da(6'h04, 8'h4A, 1'h1);
            da(6'h05, 8'h5A, 1'h1);
            da(6'h07, 8'h5F, 1'h1);
            da(6'h09, 8'h50, 1'h1);
            da(6'h0A, 8'h60, 1'h1);
            da(6'h0D, 8'h80, 1'h1);
            da(6'h0E, 8'h45, 1'h1);
            da(6'h11, 8'h20, 1'h0);
            da(6'h14, 8'h60, 1'h1);
            da(6'h33, 8'h59, 1'h1);
            da(6'h2C, 8'h46, 1'h1);
            da(6'h20, 8'h40, 1'h1);
            da(6'h3E, 8'h4F, 1'h1);
            da(6'h18, 8'h60, 1'h1);
        end
    endtask

    task t_fetch;
        begin
            wr(4'h4, 32'h0608040F, 4'hF);
            look(3'h2, 3'h2, 1'h1);
            chk({29'h0, en, sa, fa}, 32'h4);
            chk({29'h0, ap}, 32'h6);
            look(3'h2, 3'h3, 1'h1);
            chk({29'h0, en, sa, fa}, 32'h7);
            look(3'h2, 3'h3, 1'h0);
            chk({29'h0, en, sa, fa}, 32'h6);
            wr(4'h4, 32'h1008040F, 4'hF);
            look(3'h2, 3'h3, 1'h1);
            chk({29'h0, en, sa, fa}, 32'h6);
            wr(4'h4, 32'h0008FF0D, 4'hF);
            look(3'h2, 3'h5, 1'h1);
            chk({29'h0, en, sa, fa}, 32'h7);
            wr(4'h4, 32'h0008000C, 4'hF); // small region, zero field
            look(3'h2, 3'h5, 1'h1);
            chk({29'h0, en, sa, fa}, 32'h0);
            look(3'h1, 3'h5, 1'h1);
            chk({29'h0, en, sa, fa}, 32'h0);
        end
    endtask

    // reset in mid-run clears the selector and the region 2 attribute word
    task t_reset;
        begin
            @(posedge aclk);
            aresetn <= 1'h0;
            repeat (2) @(posedge aclk);
            aresetn <= 1'h1;
            rd(4'h0);
            chk(data, 32'h0);
            wr(4'h0, 32'h2, 4'hF);
            rd(4'h4);
            chk(data, 32'h0);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reset for 8 cycles, then the scenarios
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        t_bus;
        t_decode;
        t_fetch;
        t_reset;
        final_report;
    end

    // watchdog well past the expected run length
    initial begin
        #200000;
        err_total = err_total + 1;
        final_report;
    end
endmodule
